//--- core/aux_tmr_core.v
// Aux up-counting timer core with AXI4-Lite register slave
`timescale 1ns/1ps
`include "aux_tmr_map.vh"

// Functional notes
// - Run bit set/cleared by action bits, single-shot
// - Counter clear loads zero, run unaffected
// - Shadow enable set only via set bit, cleared by clear bit or shadow transfer on timer clock
// - Counter writes ignored while running
// - Period write hits shadow, read active
// - Input select 00 uses prescaled clock
// - Prescaler held clear while stopped
// - Divide by 2^n, extra times 256
// - Counter mode: software step or pin edge
// - Period lasts period value plus one
// - Count up, wrap to zero after match
// - Single shot stops at period end
// - Selected main event sets run bit
// - Trigger select picks start event
// - Direction qualifier gates trigger
// - Period match and zero match outputs
// - Shadow copy when stopped or matched
module aux_tmr_core
(
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite write address
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   // AXI4-Lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read address
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   // AXI4-Lite read data
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Main timer events
   input  wire        main_ch0_compare_event,
   input  wire        main_ch1_compare_event,
   input  wire        main_ch2_compare_event,
   input  wire        main_period_match,
   input  wire        main_zero_match,
   input  wire        main_count_direction,
   input  wire        hall_change,
   // External count pin
   input  wire        aux_external_input,
   // Timer outputs
   output reg  [15:0] aux_counter,
   output reg         aux_period_match,
   output reg         aux_zero_match,
   output reg         aux_shadow_transfer,
   output reg         aux_run_bit
);

   // ************
   // State
   // ************
   reg  [2:0]  clk_sel_q;        // Clock divider select
   reg         pre_q;            // Extra divide by 256
   reg         ste_q;            // Shadow transfer enable
   reg         ssc_q;            // Single shot
   reg  [2:0]  tec_q;            // Trigger event select
   reg  [1:0]  ted_q;            // Trigger direction qualifier
   reg  [1:0]  insel_q;          // Count input select
   reg  [15:0] per_q;            // Active period
   reg  [15:0] pers_q;           // Period shadow
   reg  [7:0]  awaddr_q;         // Latched write address
   reg         aw_have_q;        // Write address held
   reg  [31:0] wdata_q;          // Latched write data
   reg  [3:0]  wstrb_q;          // Latched strobes
   reg         w_have_q;         // Write data held
   reg         step_q;           // Software step request
   reg         st_pend_q;        // Shadow transfer waiting for timer clock

   wire        pre_tick;         // Prescaler enable
   wire        ext_rise;         // Pin rising edge
   wire        ext_fall;         // Pin falling edge
   wire        wr_go;            // Write commits this cycle
   wire        wr_ok;            // Write address mapped
   reg         tclk;             // Timer clock enable
   reg         trig_evt;         // Selected main event
   reg         dir_ok;           // Direction qualifier passes

   assign wr_go = aw_have_q & w_have_q & ~s_axi_bvalid;
   assign wr_ok = (awaddr_q[7:2] <= `AUXT_STATUS_OFF >> 2);

   // ************
   // Submodules
   // ************
   aux_tmr_prescaler #(.PW(15)) u_pre
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .run     (aux_run_bit),
      .clk_sel (clk_sel_q),
      .extra   (pre_q),
      .tick    (pre_tick)
   );

   aux_tmr_sync u_sync
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .din     (aux_external_input),
      .rise    (ext_rise),
      .fall    (ext_fall)
   );

   // ************
   // Timer clock and trigger selection
   // ************
   always @*
   begin
      case (insel_q)
         `AUXT_IS_TIMER:  tclk = pre_tick;
         `AUXT_IS_SWSTEP: tclk = step_q;
         `AUXT_IS_RISE:   tclk = ext_rise;
         default:         tclk = ext_fall;
      endcase
      case (tec_q)
         3'b001:  trig_evt = main_ch0_compare_event;
         3'b010:  trig_evt = main_ch1_compare_event;
         3'b011:  trig_evt = main_ch2_compare_event;
         3'b100:  trig_evt = main_ch0_compare_event | main_ch1_compare_event
                             | main_ch2_compare_event;
         3'b101:  trig_evt = main_period_match;
         3'b110:  trig_evt = main_zero_match & ~main_count_direction;
         3'b111:  trig_evt = hall_change;
         default: trig_evt = 1'b0;
      endcase
      case (ted_q)
         2'b01:   dir_ok = ~main_count_direction;
         2'b10:   dir_ok = main_count_direction;
         2'b11:   dir_ok = 1'b1;
         default: dir_ok = 1'b0;
      endcase
   end

   // ************
   // AXI4-Lite write channel
   // ************
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= 2'b00;
         aw_have_q     <= 1'b0;
         w_have_q      <= 1'b0;
         awaddr_q      <= 8'h00;
         wdata_q       <= 32'h0000_0000;
         wstrb_q       <= 4'h0;
      end
      else
      begin
         // Capture address and data in either order
         if (s_axi_awvalid && s_axi_awready)
         begin
            awaddr_q      <= s_axi_awaddr;
            aw_have_q     <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
            w_have_q     <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         // Commit and respond
         if (wr_go)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // ************
   // Control registers and counter
   // ************
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         clk_sel_q           <= 3'h0;
         pre_q               <= 1'b0;
         ste_q               <= 1'b0;
         ssc_q               <= 1'b0;
         tec_q               <= 3'h0;
         ted_q               <= 2'h0;
         insel_q             <= `AUXT_IS_TIMER;
         per_q               <= `AUXT_PER_RESET;
         pers_q              <= `AUXT_PER_RESET;
         step_q              <= 1'b0;
         st_pend_q           <= 1'b0;
         aux_run_bit         <= 1'b0;
         aux_counter         <= `AUXT_CNT_CLEAR;
         aux_period_match    <= 1'b0;
         aux_zero_match      <= 1'b1;
         aux_shadow_transfer <= 1'b0;
      end
      else
      begin
         step_q              <= 1'b0;
         aux_shadow_transfer <= 1'b0;
         // Shadow transfer request: stopped, or matched with enable
         if (!aux_run_bit || (ste_q && aux_period_match))
            st_pend_q <= 1'b1;
         // Counting on the timer clock
         if (tclk)
         begin
            if (aux_run_bit)
            begin
               if (aux_counter == per_q)
               begin
                  aux_counter <= `AUXT_CNT_CLEAR;
                  if (ssc_q)
                     aux_run_bit <= 1'b0;
               end
               else
                  aux_counter <= aux_counter + 16'h0001;
            end
            if (st_pend_q)
            begin
               per_q               <= pers_q;
               ste_q               <= 1'b0;
               st_pend_q           <= 1'b0;
               aux_shadow_transfer <= 1'b1;
            end
         end
         // Stopped timer has no prescaler tick, so transfer on plain clock
         if (!aux_run_bit && insel_q == `AUXT_IS_TIMER)
         begin
            per_q               <= pers_q;
            aux_shadow_transfer <= 1'b1;
         end
         // Hardware start from main timer event
         if (trig_evt && dir_ok)
            aux_run_bit <= 1'b1;
         // Register writes
         if (wr_go && wstrb_q[0])
         begin
            case (awaddr_q)
               `AUXT_CTRL_OFF:
               begin
                  clk_sel_q <= wdata_q[`AUXT_CTRL_CLK_LSB+2:`AUXT_CTRL_CLK_LSB];
                  pre_q     <= wdata_q[`AUXT_CTRL_PRE_BIT];
                  ssc_q     <= wdata_q[`AUXT_CTRL_SSC_BIT];
               end
               `AUXT_ACTION_OFF:
               begin
                  if (wdata_q[`AUXT_ACT_RUN_SET])
                     aux_run_bit <= 1'b1;
                  if (wdata_q[`AUXT_ACT_RUN_CLR])
                     aux_run_bit <= 1'b0;
                  if (wdata_q[`AUXT_ACT_CNT_CLR])
                     aux_counter <= `AUXT_CNT_CLEAR;
                  if (wdata_q[`AUXT_ACT_STE_SET])
                     ste_q <= 1'b1;
                  if (wdata_q[`AUXT_ACT_STE_CLR])
                     ste_q <= 1'b0;
                  if (wdata_q[`AUXT_ACT_STEP] && insel_q == `AUXT_IS_SWSTEP)
                     step_q <= 1'b1;
               end
               `AUXT_INSEL_OFF:
                  insel_q <= wdata_q[1:0];
               `AUXT_COUNT_OFF:
                  if (!aux_run_bit)
                     aux_counter <= wdata_q[15:0];
               `AUXT_PERIOD_OFF:
                  pers_q <= wdata_q[15:0];
               default:
                  pers_q <= pers_q;
            endcase
         end
         if (wr_go && wstrb_q[1])
         begin
            case (awaddr_q)
               `AUXT_CTRL_OFF:
               begin
                  tec_q <= wdata_q[`AUXT_CTRL_TEC_LSB+2:`AUXT_CTRL_TEC_LSB];
                  ted_q <= wdata_q[`AUXT_CTRL_TED_LSB+1:`AUXT_CTRL_TED_LSB];
               end
               `AUXT_COUNT_OFF:
                  if (!aux_run_bit)
                     aux_counter[15:8] <= wdata_q[15:8];
               `AUXT_PERIOD_OFF:
                  pers_q[15:8] <= wdata_q[15:8];
               default:
                  pers_q <= pers_q;
            endcase
         end
         // Match flags follow the counter one cycle later
         aux_period_match <= (aux_counter == per_q);
         aux_zero_match   <= (aux_counter == `AUXT_CNT_CLEAR);
      end
   end

   // ************
   // AXI4-Lite read channel
   // ************
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= 2'b00;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= 2'b00;
         case (s_axi_araddr)
            `AUXT_CTRL_OFF:
               s_axi_rdata <= {19'h0, ted_q, tec_q, 1'b0, ssc_q, ste_q,
                               aux_run_bit, pre_q, clk_sel_q};
            `AUXT_ACTION_OFF:
               s_axi_rdata <= 32'h0000_0000;
            `AUXT_INSEL_OFF:
               s_axi_rdata <= {30'h0, insel_q};
            `AUXT_COUNT_OFF:
               s_axi_rdata <= {16'h0, aux_counter};
            `AUXT_PERIOD_OFF:
               s_axi_rdata <= {16'h0, per_q};
            `AUXT_STATUS_OFF:
               s_axi_rdata <= {29'h0, aux_shadow_transfer, aux_zero_match,
                               aux_period_match};
            default:
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= 2'b10;
            end
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule

//--- core/aux_tmr_map.vh
// Register offsets, field positions, reset values and timing constants of the aux timer core
`ifndef AUX_TMR_MAP_VH
`define AUX_TMR_MAP_VH

// ************
// Register byte offsets
// ************
`define AUXT_CTRL_OFF    8'h00
`define AUXT_ACTION_OFF  8'h04
`define AUXT_INSEL_OFF   8'h08
`define AUXT_COUNT_OFF   8'h0c
`define AUXT_PERIOD_OFF  8'h10
`define AUXT_STATUS_OFF  8'h14

// ************
// Control register fields
// ************
`define AUXT_CTRL_CLK_LSB    0
`define AUXT_CTRL_PRE_BIT    3
`define AUXT_CTRL_RUN_BIT    4
`define AUXT_CTRL_STE_BIT    5
`define AUXT_CTRL_SSC_BIT    6
`define AUXT_CTRL_TEC_LSB    8
`define AUXT_CTRL_TED_LSB    11

// ************
// Action register bits, write only
// ************
`define AUXT_ACT_RUN_SET   0
`define AUXT_ACT_RUN_CLR   1
`define AUXT_ACT_CNT_CLR   2
`define AUXT_ACT_STE_SET   3
`define AUXT_ACT_STE_CLR   4
`define AUXT_ACT_STEP      5

// ************
// Input select codes
// ************
`define AUXT_IS_TIMER    2'b00
`define AUXT_IS_SWSTEP   2'b01
`define AUXT_IS_RISE     2'b10
`define AUXT_IS_FALL     2'b11

// ************
// Reset values and timing
// ************
`define AUXT_CNT_CLEAR   16'h0000
`define AUXT_PER_RESET   16'h0000
`define AUXT_EXTRA_SHIFT 8

`endif

//--- core/aux_tmr_prescaler.v
// Timer mode prescaler producing a one-cycle count enable
`timescale 1ns/1ps
`include "aux_tmr_map.vh"

module aux_tmr_prescaler
#(
   parameter PW = 15
)
(
   // Clock and reset
   input  wire       aclk,
   input  wire       aresetn,
   // Control
   input  wire       run,
   input  wire [2:0] clk_sel,
   input  wire       extra,
   // Enable out
   output reg        tick
);

   reg  [PW-1:0] div_q;   // Free running divider
   wire [3:0]    shift;   // Total power of two
   wire [PW-1:0] mask;    // Low bits that must be all ones

   assign shift = {1'b0, clk_sel} + (extra ? 4'h8 : 4'h0);
   assign mask  = ({PW{1'b1}} >> (PW - shift)) & {PW{(shift != 4'h0)}};

   // ****************************************************************
   // Divider held clear while stopped
   // ****************************************************************
   always @(posedge aclk)
   begin
      if (!aresetn || !run)
      begin
         div_q <= {PW{1'b0}};
         tick  <= 1'b0;
      end
      else
      begin
         div_q <= div_q + {{(PW-1){1'b0}}, 1'b1};
         tick  <= ((div_q & mask) == mask);
      end
   end

endmodule

//--- core/aux_tmr_sync.v
// Two-stage synchroniser with edge detection for the external count input
`timescale 1ns/1ps

module aux_tmr_sync
(
   // Clock and reset
   input  wire aclk,
   input  wire aresetn,
   // Pin
   input  wire din,
   // Edges
   output reg  rise,
   output reg  fall
);

   reg s1_q;    // First stage, read only by second
   reg s2_q;    // Second stage
   reg s3_q;    // Previous value

   // ****************************************************************
   // Synchronise then detect edges
   // ****************************************************************
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         rise <= 1'b0;
         fall <= 1'b0;
      end
      else
      begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         rise <= s2_q & ~s3_q;
         fall <= ~s2_q & s3_q;
      end
   end

endmodule

//--- sim/aux_tmr_core_tb.sv
// Self-checking bench for the aux timer core
`timescale 1ns/1ps
`include "aux_tmr_map.vh"

module aux_tmr_core_tb;
   // Clock, reset, bus, pins and outputs
   reg         aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
   reg         s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   reg         main_count_direction = 1'b0, aux_external_input = 1'b0;
   reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   reg  [31:0] s_axi_wdata = 32'h0;
   reg  [3:0]  s_axi_wstrb = 4'hf;
   reg  [5:0]  ev = 6'h00;          // ch0 ch1 ch2 pm zm hall
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire        aux_period_match, aux_zero_match, aux_shadow_transfer, aux_run_bit;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [15:0] aux_counter;
   // Bench state
   int         err_count = 0;
   int         comparisons = 0;
   int         i, j, k, e, f1, f2, p1, p2;
   logic [15:0] rnd = 16'h918c;     // Random source state
   logic [31:0] rv, sv;             // Read data
   logic [1:0]  rs;                 // Last response code
   logic [3:0]  cs [5] = '{4'h8, 4'h0, 4'h1, 4'h3, 4'h7}; // Clock select codes

   aux_tmr_core dut
   (
      .*, .main_ch0_compare_event(ev[0]), .main_ch1_compare_event(ev[1]),
      .main_ch2_compare_event(ev[2]), .main_period_match(ev[3]), .main_zero_match(ev[4]),
      .hall_change(ev[5])
   );

   // ***********
   // Bench tasks
   // ***********
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
      comparisons++;
      if (s !== x)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", n, x, s);
      end
   endtask

   // Bus write, payload held until each channel is taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask

   // Bus read into rv and rs
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rv = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic wrc(input string n, input logic [7:0] a, input logic [31:0] d,
                      input logic [7:0] ra, input logic [31:0] x);
      wr(a, d);
      rd(ra);
      chk(n, rv, x);
   endtask

   // Cycles until the next rise of period match
   task automatic rise(output int n);
      logic p;
      n = 0;
      do
      begin
         p = aux_period_match;
         @(posedge aclk);
         n++;
      end while (!(p === 1'b0 && aux_period_match === 1'b1) && n < 9000);
   endtask

   // Start, time two matches, stop at a random prescaler phase
   task automatic meas(output int first, output int per);
      wr(`AUXT_ACTION_OFF, 32'h1);
      rise(first);
      rise(per);
      repeat (rnd[2:0]) @(posedge aclk);
      rnd = lfsr(rnd);
      wr(`AUXT_ACTION_OFF, 32'h6);
   endtask

   task automatic end_sim;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Clock, 4 ns period
   initial
   begin
      forever #2 aclk = ~aclk;
   end

   // Hang guard
   initial
   begin
      repeat (40000) @(posedge aclk);
      err_count++;
      end_sim();
   end

   // ***********
   // Main flow
   // ***********
   initial
   begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (i = 0; i < 5; i++)
      begin
         rd(8'(i * 4));
         chk("reset value", rv, 32'h0);
      end
      rd(8'h18);
      chk("unmapped read", {rs, rv[29:0]}, 32'h80000000);
      wr(8'h18, 32'h1);
      chk("unmapped write", rs, 2'b10);
      wrc("ste", `AUXT_ACTION_OFF, 32'h8, `AUXT_CTRL_OFF, 32'h20);
      wrc("ste", `AUXT_CTRL_OFF, 32'h0, `AUXT_CTRL_OFF, 32'h20);
      wrc("ste", `AUXT_ACTION_OFF, 32'h10, `AUXT_CTRL_OFF, 32'h0);
      wrc("ste", `AUXT_CTRL_OFF, 32'h20, `AUXT_CTRL_OFF, 32'h0);
      wrc("count stopped", `AUXT_COUNT_OFF, 32'h5, `AUXT_COUNT_OFF, 32'h5);
      wr(`AUXT_COUNT_OFF, 32'h0);
      // Timer mode rates, nonzero period before every start
      for (i = 0; i < 5; i++)
      begin
         k = (i == 0) ? 1 : 3;
         wrc("period", `AUXT_PERIOD_OFF, k, `AUXT_PERIOD_OFF, k);
         wr(`AUXT_CTRL_OFF, cs[i]);
         meas(f1, p1);
         meas(f2, p2);
         chk("restart", f2, f1);
         chk("rate", p1, (k + 1) << (cs[i][2:0] + 8 * cs[i][3]));
      end
      // Running: shadow, count write, clear, transfer
      wr(`AUXT_CTRL_OFF, 32'h0);
      wr(`AUXT_ACTION_OFF, 32'h1);
      wr(`AUXT_PERIOD_OFF, 32'h7);
      wr(`AUXT_COUNT_OFF, 32'h1234);
      rd(`AUXT_COUNT_OFF);
      chk("count running", rv < 32'h4, 1);
      wrc("clear running", `AUXT_ACTION_OFF, 32'h4, `AUXT_CTRL_OFF, 32'h10);
      rd(`AUXT_PERIOD_OFF);
      chk("active period", rv, 32'h3);
      wr(`AUXT_ACTION_OFF, 32'h8);
      j = 0;
      while (aux_shadow_transfer !== 1'b1 && j < 100)
      begin
         @(posedge aclk);
         j++;
      end
      chk("transfer", j < 100, 1);
      wrc("period moved", `AUXT_CTRL_OFF, 32'h0, `AUXT_PERIOD_OFF, 32'h7);
      rd(`AUXT_CTRL_OFF);
      chk("ste cleared", rv, 32'h10);
      rise(p1);
      rise(p1);
      chk("new period", p1, 8);
      // Single shot
      wr(`AUXT_ACTION_OFF, 32'h6);
      wr(`AUXT_CTRL_OFF, 32'h40);
      wr(`AUXT_ACTION_OFF, 32'h1);
      j = 0;
      while (aux_run_bit === 1'b1 && j < 100)
      begin
         @(posedge aclk);
         j++;
      end
      chk("single shot", j > 3 && j < 12, 1);
      rd(`AUXT_COUNT_OFF);
      sv = rv;
      repeat (10) @(posedge aclk);
      rd(`AUXT_COUNT_OFF);
      chk("stopped", rv, sv);
      // Counter modes
      wr(`AUXT_CTRL_OFF, 32'h0);
      wr(`AUXT_COUNT_OFF, 32'h0);
      wr(`AUXT_INSEL_OFF, 32'h1);
      wr(`AUXT_ACTION_OFF, 32'h1);
      k = 1 + rnd % 6;
      rnd = lfsr(rnd);
      repeat (k) wr(`AUXT_ACTION_OFF, 32'h20);
      rd(`AUXT_COUNT_OFF);
      chk("sw step", rv, k);
      for (i = 2; i < 4; i++)
      begin
         wr(`AUXT_INSEL_OFF, i);
         wr(`AUXT_ACTION_OFF, 32'h4);
         e = 0;
         repeat (8)
         begin
            aux_external_input <= rnd[0];
            if (rnd[0] != aux_external_input && rnd[0] == (i == 2))
               e++;
            rnd = lfsr(rnd);
            repeat (5) @(posedge aclk);
         end
         repeat (6) @(posedge aclk);
         rd(`AUXT_COUNT_OFF);
         chk("pin edges", rv, e % 8);
      end
      // Start events: tec i[2:0], ted i[4:3], direction i[5]
      wr(`AUXT_INSEL_OFF, 32'h0);
      wr(`AUXT_ACTION_OFF, 32'h6);
      for (i = 0; i < 64; i++)
      begin
         wr(`AUXT_CTRL_OFF, (i & 31) << 8);
         k = (i[2:0] == 4) ? rnd % 3 : i[2:0] - 1 - (i[2:0] > 4);
         rnd = lfsr(rnd);
         main_count_direction <= i[5];
         ev <= (i[2:0] == 0) ? 6'h3f : 6'h01 << k;
         @(posedge aclk);
         ev <= 6'h00;
         repeat (4) @(posedge aclk);
         e = i[2:0] != 0 && i[3 + i[5]] && !(i[2:0] == 6 && i[5]);
         chk("trigger", aux_run_bit, e);
         wr(`AUXT_ACTION_OFF, 32'h6);
      end
      end_sim();
   end
endmodule

//--- sim/aux_tmr_properties.sv
// Port level assertions for the aux timer core
`timescale 1ns/1ps
`include "aux_tmr_map.vh"

module aux_tmr_properties
(
   // Clock and reset
   input wire        aclk,
   input wire        aresetn,
   // Write bus
   input wire [7:0]  s_axi_awaddr,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   // Main timer events
   input wire        main_ch0_compare_event,
   input wire        main_ch1_compare_event,
   input wire        main_ch2_compare_event,
   input wire        main_period_match,
   input wire        main_zero_match,
   input wire        main_count_direction,
   input wire        hall_change,
   // Timer outputs
   input wire [15:0] aux_counter,
   input wire        aux_period_match,
   input wire        aux_zero_match,
   input wire        aux_run_bit
);
   // ************
   // Helper logic
   // ************
   reg [7:0]  wa_q;  // Captured write address
   reg [31:0] wd_q;  // Captured write data
   reg [2:0]  tec_q; // Trigger select copy
   reg [1:0]  ted_q; // Direction qualifier copy
   reg        bv_q;  // Delayed response valid
   wire       cmt = s_axi_bvalid && !bv_q; // Write commit cycle
   wire       act = cmt && wa_q == `AUXT_ACTION_OFF;
   wire [7:0] evs = {hall_change, main_zero_match && !main_count_direction, main_period_match,
                     main_ch0_compare_event | main_ch1_compare_event | main_ch2_compare_event,
                     main_ch2_compare_event, main_ch1_compare_event, main_ch0_compare_event,
                     1'b0};
   wire       trig = evs[tec_q] && ted_q[main_count_direction]; // Selected start event

   // Track bus payloads and trigger fields
   always @(posedge aclk)
   begin
      if (s_axi_awvalid && s_axi_awready)
         wa_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
         wd_q <= s_axi_wdata;
      bv_q <= s_axi_bvalid;
      if (!aresetn)
      begin
         tec_q <= 3'h0;
         ted_q <= 2'h0;
      end
      else if (cmt && wa_q == `AUXT_CTRL_OFF)
      begin
         tec_q <= wd_q[10:8];
         ted_q <= wd_q[12:11];
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_run_set;
      act && wd_q[0] && !wd_q[1] |-> aux_run_bit;
   endproperty
   a_run_set: assert property (p_run_set) else $error("run bit not set");
   property p_run_clr;
      act && wd_q[1] |-> !aux_run_bit;
   endproperty
   a_run_clr: assert property (p_run_clr) else $error("run bit not cleared");
   property p_cnt_clr;
      act && wd_q[2:0] == 3'h4 |-> aux_counter == `AUXT_CNT_CLEAR && $stable(aux_run_bit);
   endproperty
   a_cnt_clr: assert property (p_cnt_clr) else $error("counter clear wrong");
   property p_cnt_wr;
      cmt && wa_q == `AUXT_COUNT_OFF && !aux_run_bit && !$past(aux_run_bit)
         |-> aux_counter == wd_q[15:0];
   endproperty
   a_cnt_wr: assert property (p_cnt_wr) else $error("counter write lost");
   property p_count_up;
      aux_run_bit && $past(aux_run_bit) && !cmt && $changed(aux_counter)
         |-> aux_counter == $past(aux_counter) + 16'h0001 || aux_counter == 16'h0000;
   endproperty
   a_count_up: assert property (p_count_up) else $error("counter stepped wrong");
   property p_zero;
      aux_zero_match == ($past(aux_counter) == 16'h0000);
   endproperty
   a_zero: assert property (p_zero) else $error("zero match wrong");
   property p_single;
      $fell(aux_run_bit) && !(act && wd_q[1]) |-> aux_period_match || $past(aux_period_match);
   endproperty
   a_single: assert property (p_single) else $error("stop outside period end");
   property p_trig;
      trig && !aux_run_bit |-> ##[1:2] aux_run_bit;
   endproperty
   a_trig: assert property (p_trig) else $error("trigger did not start");
endmodule

bind aux_tmr_core aux_tmr_properties u_props (.*);
